// ==== flash_reset_pkg.sv ====
package flash_reset_pkg;
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned CLK_PERIOD_NS = 1000 / CLK_MHZ;
  // times in their own units, counts derived
  localparam int unsigned RESET_PULSE_MIN_NS = 200;
  localparam int unsigned RESET_RECOVERY_TIME_US = 100;
  localparam int unsigned RESET_HOLD_TIME_NS = 150;
  localparam int unsigned RESET_SETUP_TIME_NS = 50;
  localparam int unsigned DESELECT_GUARD_TIME_NS = 50;
  localparam int unsigned POWERUP_DELAY_US = 300;
  // least times round up
  localparam int unsigned RESET_PULSE_MIN_CYC =
    (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESET_RECOVERY_CYC =
    (RESET_RECOVERY_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESET_HOLD_CYC =
    (RESET_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESET_SETUP_CYC =
    (RESET_SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DESELECT_GUARD_CYC =
    (DESELECT_GUARD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned POWERUP_DELAY_CYC =
    (POWERUP_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 24;
  // command opcodes
  localparam logic [7:0] RESET_ARM_COMMAND = 8'h66;
  localparam logic [7:0] RESET_FIRE_COMMAND = 8'h99;
  localparam logic [7:0] WAKE_FROM_SLEEP_COMMAND = 8'hab;
  // configuration bit positions
  localparam int unsigned QUAD_ENABLE_BIT = 1;
  localparam int unsigned QUAD_COMMAND_MODE_BIT = 3;
  localparam int unsigned LANE3_RESET_ENABLE_BIT = 7;

  typedef enum logic [2:0] {
    ST_POWERUP = 3'b000,
    ST_READY = 3'b001,
    ST_HW_RESET = 3'b010,
    ST_SW_RESET = 3'b011,
    ST_HOLD_LOW = 3'b100,
    ST_SLEEP = 3'b101
  } seq_state_t;

  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
  } command_t;

  typedef struct packed {
    logic busy;
    logic outputs_hiz;
    logic regs_reset;
    logic operation_abort;
    logic cs_allowed;
  } seq_status_t;
endpackage

// ==== reset_pulse_filter.sv ====
`timescale 1ns/10ps
`default_nettype none
// qualifies a low level lasting more than MIN_CYC cycles
module reset_pulse_filter
  import flash_reset_pkg::*;
#(
  parameter int unsigned MIN_CYC = RESET_PULSE_MIN_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic active_low,
  input wire logic enable,
  output logic qualified,
  output logic is_high
);
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic next_qualified;

  always_comb begin
    next_cnt = cnt;
    next_qualified = 1'b0;
    if (!enable || active_low) begin
      next_cnt = 16'h0000;
    end else if (cnt < 16'(MIN_CYC)) begin
      next_cnt = cnt + 16'h0001;
    end
    // glitches shorter than the minimum never qualify
    if (enable && !active_low && cnt >= 16'(MIN_CYC)) begin
      next_qualified = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt <= 16'h0000;
      qualified <= 1'b0;
      is_high <= 1'b1;
    end else begin
      cnt <= next_cnt;
      qualified <= next_qualified;
      is_high <= active_low;
    end
  end
endmodule
`default_nettype wire

// ==== flash_reset_sequencer.sv ====
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - reset during erase, program or register write aborts it; contents undefined.
// - hardware reset during a software reset is ignored.
// - both reset pins are ignored during power-on reset.
// - shared pin resets only after guard time deselected, or quad off.
// - dedicated pin low over pulse minimum resets registers, recovery time.
// - in quad, guard time after deselect masks shared pin; selected means data lane.
// - failed power-on makes a reset pin restart the full power-up.
// - arm command then fire command runs software reset, pins independent.
// - clearing the nonvolatile enable bit makes lane 3 data only.
// - shared-pin reset aborts, floats outputs, ignores commands, standby.
// - after quad read the device drives lane 3 high during guard time.
// - reset held at power-up end keeps reset; hold time gates select.
// - in deep sleep only wake command or hardware reset act.
module flash_reset_sequencer
  import flash_reset_pkg::*;
#(
  parameter int unsigned POWERUP_CYC = POWERUP_DELAY_CYC,
  parameter int unsigned RECOVERY_CYC = RESET_RECOVERY_CYC,
  parameter int unsigned GUARD_CYC = DESELECT_GUARD_CYC,
  parameter int unsigned HOLD_CYC = RESET_HOLD_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic supply_good,
  input wire logic powerup_ok,
  input wire logic cs_n,
  input wire logic reset_n,
  input wire logic lane3_shared_reset_pin_i,
  input wire logic [7:0] config_one_volatile,
  input wire logic [7:0] config_two_volatile,
  input wire logic [7:0] config_two_nonvolatile,
  input wire logic quad_read_done,
  input wire command_t cmd,
  input wire logic sleep_request,
  output logic lane3_shared_reset_pin_o,
  output logic lane3_shared_reset_pin_oe,
  output seq_status_t status,
  output logic deep_sleep_state,
  output logic sw_reset_done,
  output logic command_accepted
);
  seq_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [7:0] guard, next_guard;
  logic armed, next_armed;
  logic por_failed, next_por_failed;
  logic quad_drive, next_quad_drive;
  seq_status_t next_status;
  logic next_sleep, next_sw_done, next_cmd_acc;
  logic next_l3_oe;
  logic quad_on, lane3_en, guard_done, lane3_active;
  logic ded_q, ded_high, l3_q, l3_high, hw_req;

  assign quad_on = config_one_volatile[QUAD_ENABLE_BIT] &&
                   config_two_volatile[QUAD_COMMAND_MODE_BIT];
  assign lane3_en = config_two_nonvolatile[LANE3_RESET_ENABLE_BIT];
  assign guard_done = cs_n && (guard >= 8'(GUARD_CYC));
  assign lane3_active = lane3_en && (guard_done || !quad_on);

  reset_pulse_filter #(.MIN_CYC(RESET_PULSE_MIN_CYC)) u_ded (
    .clk(clk),
    .srst(srst),
    .active_low(reset_n),
    .enable(1'b1),
    .qualified(ded_q),
    .is_high(ded_high)
  );

  reset_pulse_filter #(.MIN_CYC(RESET_PULSE_MIN_CYC)) u_l3 (
    .clk(clk),
    .srst(srst),
    .active_low(lane3_shared_reset_pin_i),
    .enable(lane3_active),
    .qualified(l3_q),
    .is_high(l3_high)
  );

  assign hw_req = ded_q || l3_q;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_guard = guard;
    next_armed = armed;
    next_por_failed = por_failed;
    next_quad_drive = quad_drive;
    next_sw_done = 1'b0;
    next_cmd_acc = 1'b0;
    if (!cs_n) begin
      next_guard = 8'h00;
      next_quad_drive = 1'b0;
    end else if (guard < 8'(GUARD_CYC)) begin
      next_guard = guard + 8'h01;
    end
    if (quad_read_done && quad_on) begin
      next_quad_drive = 1'b1;
    end else if (guard_done) begin
      next_quad_drive = 1'b0;
    end
    case (state)
      ST_POWERUP: begin
        // pins ignored here
        if (!supply_good) begin
          next_cnt = '0;
        end else if (cnt < CNT_W'(POWERUP_CYC)) begin
          next_cnt = cnt + 1'b1;
        end else begin
          next_por_failed = !powerup_ok;
          next_cnt = '0;
          // reset still low at end keeps device in reset
          if (!ded_high || (lane3_en && !l3_high)) begin
            next_state = ST_HOLD_LOW;
          end else begin
            next_state = ST_READY;
          end
        end
      end
      ST_READY, ST_SLEEP: begin
        if (hw_req) begin
          next_cnt = '0;
          next_armed = 1'b0;
          next_state = por_failed ? ST_POWERUP : ST_HW_RESET;
        end else if (cmd.valid) begin
          if (state == ST_SLEEP) begin
            if (cmd.opcode == WAKE_FROM_SLEEP_COMMAND) begin
              next_state = ST_READY;
              next_cmd_acc = 1'b1;
            end
          end else if (cmd.opcode == RESET_ARM_COMMAND) begin
            next_armed = 1'b1;
            next_cmd_acc = 1'b1;
          end else if (cmd.opcode == RESET_FIRE_COMMAND && armed) begin
            next_armed = 1'b0;
            next_cnt = '0;
            next_cmd_acc = 1'b1;
            next_state = ST_SW_RESET;
          end else begin
            next_armed = 1'b0;
            next_cmd_acc = 1'b1;
          end
        end else if (sleep_request && state == ST_READY) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SW_RESET: begin
        // pin resets are not taken while this runs
        if (cnt < CNT_W'(RECOVERY_CYC)) begin
          next_cnt = cnt + 1'b1;
        end else begin
          next_sw_done = 1'b1;
          next_state = ST_READY;
        end
      end
      ST_HW_RESET: begin
        // commands ignored for the recovery period
        if (cnt < CNT_W'(RECOVERY_CYC)) begin
          next_cnt = cnt + 1'b1;
        end else begin
          next_cnt = '0;
          next_state = ST_HOLD_LOW;
        end
      end
      ST_HOLD_LOW: begin
        if (!ded_high || (lane3_active && !l3_high)) begin
          next_cnt = '0;
        end else if (cnt < CNT_W'(HOLD_CYC)) begin
          next_cnt = cnt + 1'b1;
        end else begin
          next_state = ST_READY;
        end
      end
      default: begin
        next_state = ST_POWERUP;
        next_cnt = '0;
      end
    endcase
    next_sleep = (next_state == ST_SLEEP);
    next_l3_oe = next_quad_drive;
    next_status.busy = (next_state != ST_READY) &&
                       (next_state != ST_SLEEP);
    next_status.outputs_hiz = (next_state == ST_HW_RESET) ||
                              (next_state == ST_POWERUP) ||
                              (next_state == ST_HOLD_LOW);
    next_status.regs_reset = (state != ST_HW_RESET) &&
                             (next_state == ST_HW_RESET);
    next_status.operation_abort = next_status.regs_reset ||
      (state != ST_SW_RESET && next_state == ST_SW_RESET);
    next_status.cs_allowed = (next_state == ST_READY) ||
                             (next_state == ST_SLEEP);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ST_POWERUP;
      cnt <= '0;
      guard <= 8'h00;
      armed <= 1'b0;
      por_failed <= 1'b0;
      quad_drive <= 1'b0;
      status <= '{busy: 1'b1, outputs_hiz: 1'b1, regs_reset: 1'b0,
                  operation_abort: 1'b0, cs_allowed: 1'b0};
      deep_sleep_state <= 1'b0;
      sw_reset_done <= 1'b0;
      command_accepted <= 1'b0;
      lane3_shared_reset_pin_o <= 1'b1;
      lane3_shared_reset_pin_oe <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      guard <= next_guard;
      armed <= next_armed;
      por_failed <= next_por_failed;
      quad_drive <= next_quad_drive;
      status <= next_status;
      deep_sleep_state <= next_sleep;
      sw_reset_done <= next_sw_done;
      command_accepted <= next_cmd_acc;
      lane3_shared_reset_pin_o <= 1'b1;
      lane3_shared_reset_pin_oe <= next_l3_oe;
    end
  end

  AST_HIZ_IN_HW_RESET: assert property (@(posedge clk) disable iff (srst)
    (state == ST_HW_RESET) |-> status.outputs_hiz)
    else $error("outputs not floated in hardware reset");
  AST_NO_HW_IN_SW: assert property (@(posedge clk) disable iff (srst)
    (state == ST_SW_RESET && hw_req) |=> state != ST_HW_RESET)
    else $error("hardware reset taken during software reset");
  AST_POR_IGNORES_PINS: assert property (@(posedge clk) disable iff (srst)
    (state == ST_POWERUP && !supply_good) |=> state == ST_POWERUP)
    else $error("power-on left early");
  AST_HW_ENTRY: assert property (@(posedge clk) disable iff (srst)
    (state == ST_READY && hw_req && !por_failed) |=>
      state == ST_HW_RESET ##1 status.regs_reset == 1'b0)
    else $error("hardware reset not entered");
  AST_POR_RESTART: assert property (@(posedge clk) disable iff (srst)
    (state == ST_READY && hw_req && por_failed) |=> state == ST_POWERUP)
    else $error("failed power-on did not restart");
  AST_SW_SEQ: assert property (@(posedge clk) disable iff (srst)
    (state == ST_READY && armed && !hw_req && cmd.valid &&
     cmd.opcode == RESET_FIRE_COMMAND) |=> state == ST_SW_RESET)
    else $error("software reset not started");
  AST_L3_MASKED: assert property (@(posedge clk) disable iff (srst)
    (!lane3_en) |-> !lane3_active)
    else $error("lane 3 reset active while disabled");
  AST_GUARD_MASK: assert property (@(posedge clk) disable iff (srst)
    (!cs_n && quad_on) |-> !lane3_active)
    else $error("lane 3 reset active while selected in quad");
  AST_QUAD_DRIVE: assert property (@(posedge clk) disable iff (srst)
    (quad_read_done && quad_on && cs_n) |=> lane3_shared_reset_pin_oe)
    else $error("lane 3 not driven high after quad read");
  AST_SLEEP_ONLY_WAKE: assert property (@(posedge clk) disable iff (srst)
    (state == ST_SLEEP && !hw_req && cmd.valid &&
     cmd.opcode != WAKE_FROM_SLEEP_COMMAND) |=> state == ST_SLEEP)
    else $error("sleep left on other command");
endmodule
`default_nettype wire

// ==== flash_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// host side: chip select, dedicated reset pin and lane 3 driver
module flash_host_model
  import flash_reset_pkg::*;
(
  input wire logic clk,
  output logic cs_n,
  output logic reset_n,
  output logic lane3_drv,
  output logic lane3_en
);
  initial begin
    cs_n = 1'b1;
    reset_n = 1'b1;
    lane3_drv = 1'b1;
    lane3_en = 1'b0;
  end

  task automatic select(input logic v);
    @(negedge clk);
    cs_n = v;
  endtask

  // high for setup time plus one cycle, then low for n cycles
  task automatic reset_pulse(input int n, input logic on_lane3);
    repeat (RESET_SETUP_CYC + 1) @(negedge clk);
    if (on_lane3) begin
      lane3_en = 1'b1;
      lane3_drv = 1'b0;
    end else begin
      reset_n = 1'b0;
    end
    repeat (n) @(negedge clk);
    reset_n = 1'b1;
    lane3_drv = 1'b1;
    lane3_en = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== test_flash_reset_sequencer.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_flash_reset_sequencer;
  import flash_reset_pkg::*;
  localparam int PU = 50;
  localparam int REC = 40;
  localparam int GRD = 3;
  localparam int HLD = 8;
  logic clk, srst, supply_good, powerup_ok, quad_read_done, sleep_request;
  logic cs_n, reset_n, drv, en, lane_o, lane_oe, lane3, sleep_st;
  logic sw_done, acc;
  logic [7:0] cfg1, cfg2, cfgnv, op;
  command_t cmd;
  seq_status_t status;
  int err_total = 0, tests_run = 0;
  int n_rst = 0, n_acc = 0, n_sw = 0, n_abt = 0;
  int exp_rst = 0, exp_acc = 0, exp_sw = 0;
  // {nv enable, quad enable, quad cmd mode, selected, reset expected}
  logic [4:0] lt [5] = '{5'b10101, 5'b11110, 5'b00000, 5'b10011,
                         5'b11101};

  // pull-up when nobody drives lane 3
  assign lane3 = lane_oe ? lane_o : (en ? drv : 1'b1);

  flash_host_model flash_host_model_inst (.clk(clk), .cs_n(cs_n),
    .reset_n(reset_n), .lane3_drv(drv), .lane3_en(en));

  flash_reset_sequencer #(.POWERUP_CYC(PU), .RECOVERY_CYC(REC),
    .GUARD_CYC(GRD), .HOLD_CYC(HLD)) flash_reset_sequencer_inst (
    .clk(clk), .srst(srst), .supply_good(supply_good),
    .powerup_ok(powerup_ok), .cs_n(cs_n), .reset_n(reset_n),
    .lane3_shared_reset_pin_i(lane3), .config_one_volatile(cfg1),
    .config_two_volatile(cfg2), .config_two_nonvolatile(cfgnv),
    .quad_read_done(quad_read_done), .cmd(cmd),
    .sleep_request(sleep_request), .lane3_shared_reset_pin_o(lane_o),
    .lane3_shared_reset_pin_oe(lane_oe), .status(status),
    .deep_sleep_state(sleep_st), .sw_reset_done(sw_done),
    .command_accepted(acc));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    if (status.regs_reset === 1'b1) n_rst++;
    if (acc === 1'b1) n_acc++;
    if (sw_done === 1'b1) n_sw++;
    if (status.operation_abort === 1'b1) n_abt++;
  end

  task automatic check(input string name, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wait_ready(input int limit);
    int i;
    for (i = 0; i < limit && status.cs_allowed !== 1'b1; i++) step(1);
    check("cs_allowed", status.cs_allowed, 1'b1);
  endtask

  task automatic send(input logic [7:0] code);
    @(negedge clk);
    cmd = '{valid: 1'b1, opcode: code};
    @(negedge clk);
    cmd.valid = 1'b0;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #(20 * 20000);
    err_total++;
    test_done();
  end

  initial begin
    srst = 1'b1;
    supply_good = 1'b1;
    powerup_ok = 1'b1;
    quad_read_done = 1'b0;
    sleep_request = 1'b0;
    cfg1 = 8'h00;
    cfg2 = 8'h00;
    cfgnv = 8'h80;
    cmd = '0;
    void'($urandom(53));
    repeat (5) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    check("busy_at_start", status.busy, 1'b1);
    check("hiz_at_start", status.outputs_hiz, 1'b1);
    flash_host_model_inst.reset_pulse(15, 1'b0);
    wait_ready(PU + 40);
    check("rst_in_powerup", n_rst, exp_rst);
    flash_host_model_inst.reset_pulse(1 + $urandom % 8, 1'b0);
    step(20);
    check("short_pulse", n_rst, exp_rst);
    flash_host_model_inst.reset_pulse(12, 1'b0);
    step(2);
    exp_rst++;
    check("hw_rst", n_rst, exp_rst);
    check("hw_hiz", status.outputs_hiz, 1'b1);
    check("hw_cs_block", status.cs_allowed, 1'b0);
    wait_ready(REC + HLD + 40);
    for (int k = 0; k < 5; k++) begin
      cfg1 = {6'h00, lt[k][3], 1'b0};
      cfg2 = {4'h0, lt[k][2], 3'h0};
      cfgnv = {lt[k][4], 7'h00};
      flash_host_model_inst.select(~lt[k][1]);
      step(GRD + 2);
      flash_host_model_inst.reset_pulse(12, 1'b1);
      flash_host_model_inst.select(1'b1);
      step(3);
      exp_rst += lt[k][0];
      check("lane3_rst", n_rst, exp_rst);
      wait_ready(REC + HLD + 40);
    end
    flash_host_model_inst.select(1'b0);
    // quad read ends as select rises
    fork
      flash_host_model_inst.select(1'b1);
      begin
        @(negedge clk);
        quad_read_done = 1'b1;
      end
    join
    @(negedge clk);
    quad_read_done = 1'b0;
    check("lane3_drive_en", lane_oe, 1'b1);
    check("lane3_drive_hi", lane_o, 1'b1);
    step(GRD + 3);
    check("lane3_release", lane_oe, 1'b0);
    send(RESET_ARM_COMMAND);
    send(RESET_FIRE_COMMAND);
    exp_acc += 2;
    exp_sw++;
    // pin reset while the software reset runs is dropped
    flash_host_model_inst.reset_pulse(12, 1'b0);
    step(REC + 10);
    check("sw_rst", n_sw, exp_sw);
    check("hw_in_sw", n_rst, exp_rst);
    wait_ready(HLD + 40);
    op = 8'($urandom);
    if (op == 8'h66 || op == 8'h99 || op == 8'hab) op = 8'h00;
    send(RESET_ARM_COMMAND);
    send(op);
    send(RESET_FIRE_COMMAND);
    exp_acc += 3;
    step(5);
    check("sw_disarm", n_sw, exp_sw);
    check("accepts", n_acc, exp_acc);
    @(negedge clk);
    sleep_request = 1'b1;
    @(negedge clk);
    sleep_request = 1'b0;
    step(2);
    check("sleep", sleep_st, 1'b1);
    send(RESET_ARM_COMMAND);
    step(2);
    check("sleep_ignore", n_acc, exp_acc);
    send(WAKE_FROM_SLEEP_COMMAND);
    exp_acc++;
    step(3);
    check("wake_acc", n_acc, exp_acc);
    check("wake", sleep_st, 1'b0);
    // mid-run power cycle: late supply, failed power-on, pin low at end
    @(negedge clk);
    srst = 1'b1;
    supply_good = 1'b0;
    powerup_ok = 1'b0;
    step(2);
    srst = 1'b0;
    step(PU + 10);
    check("supply_low", status.cs_allowed, 1'b0);
    supply_good = 1'b1;
    flash_host_model_inst.reset_pulse(PU + 10, 1'b0);
    check("pin_low_at_end", status.cs_allowed, 1'b0);
    wait_ready(HLD + 20);
    check("no_regs_reset", n_rst, exp_rst);
    powerup_ok = 1'b1;
    flash_host_model_inst.reset_pulse(12, 1'b0);
    step(PU / 2);
    check("por_restart", status.busy, 1'b1);
    check("por_no_regs", n_rst, exp_rst);
    wait_ready(PU + 20);
    check("aborts", n_abt, exp_rst + exp_sw);
    test_done();
  end
endmodule
`default_nettype wire
